/* sac_consts.svh */
// Register offsets, field positions and reset values of the converter control block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// Byte offsets on the register bus
`define SAC_OFF_CTRL1 7'h00
`define SAC_OFF_CTRL2 7'h04
`define SAC_OFF_CTRL3 7'h08
`define SAC_OFF_IRQ_STATUS 7'h0C
`define SAC_OFF_IRQ_MASK 7'h10
`define SAC_BUF_SEL_BIT 6
// Control one fields
`define SAC_B_ON 15
`define SAC_B_IDLE_STOP 13
`define SAC_B_RES 10
`define SAC_F_FMT 9:8
`define SAC_F_TRIG 7:5
`define SAC_B_SIM 3
`define SAC_B_AUTO_SAMPLE 2
`define SAC_B_SAMPLE_ACTIVE 1
`define SAC_B_DONE 0
// Control two and three fields
`define SAC_F_CHCOUNT 9:8
`define SAC_F_INSEL 2:0
`define SAC_F_SAMPLE_TIME 12:8
`define SAC_F_DIV 5:0
// Interrupt status and mask bits
`define SAC_B_IRQ_DONE 0
`define SAC_B_IRQ_WRAP 1
// Reset values and limits
`define SAC_RST_FMT 2'h0
`define SAC_RST_TRIG 3'h0
`define SAC_RST_CHCOUNT 2'h0
`define SAC_RST_INSEL 3'h0
`define SAC_RST_SAMPLE_TIME 5'h00
`define SAC_RST_DIV 6'h00
`define SAC_RST_IRQ 2'h0
`define SAC_INSEL_MAX 3'h5
`endif

/* sac_pkg.sv */
// Types shared by the converter control block
package sac_pkg;
  typedef logic [31:0] sac_bus_t;
  typedef logic [15:0] sac_word_t;
  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} sac_state_e;
  typedef enum logic [2:0] {
    TRIG_MANUAL = 3'h0,
    TRIG_EXT_PIN = 3'h1,
    TRIG_TIMER = 3'h2,
    TRIG_PWM1 = 3'h3,
    TRIG_RSVD4 = 3'h4,
    TRIG_PWM2 = 3'h5,
    TRIG_RSVD6 = 3'h6,
    TRIG_AUTO = 3'h7
  } sac_trig_e;
endpackage

/* sac_fmt_if.sv */
// Interface carrying a raw result to the formatter and the formatted word back
`timescale 1ns/1ps
`default_nettype none
interface sac_fmt_if;
  logic [11:0] raw;
  logic res12;
  logic [1:0] fmt;
  logic [15:0] word;
  modport ctrl (output raw, output res12, output fmt, input word);
  modport conv (input raw, input res12, input fmt, output word);
endinterface
`default_nettype wire

/* sac_result_format.sv */
// Result formatter: lays out a raw 10-bit or 12-bit result in a 16-bit word
`timescale 1ns/1ps
`default_nettype none
module sac_result_format (
  sac_fmt_if.conv f
);
  import sac_pkg::*;
  // Layout per resolution and format code
  always_comb begin
    f.word = 16'h0000;
    if (f.res12) begin
      unique case (f.fmt)
        2'h0: f.word = {4'h0, f.raw};
        2'h1: f.word = {{5{~f.raw[11]}}, f.raw[10:0]};
        2'h2: f.word = {f.raw, 4'h0};
        2'h3: f.word = {~f.raw[11], f.raw[10:0], 4'h0};
      endcase
    end else begin
      unique case (f.fmt)
        2'h0: f.word = {6'h00, f.raw[9:0]};
        2'h1: f.word = {{7{~f.raw[9]}}, f.raw[8:0]};
        2'h2: f.word = {f.raw[9:0], 6'h00};
        2'h3: f.word = {~f.raw[9], f.raw[8:0], 6'h00};
      endcase
    end
  end
endmodule // sac_result_format
`default_nettype wire

/* sac_control.sv */
// Converter sequencing control with Avalon-MM register slave
// Summary of operation
// - Mode bit picks 10-bit/4 S&H or 12-bit/1
// - 12-bit: simultaneous bit reads zero, ignores writes
// - Results land in a sixteen-word buffer
// - Six analog inputs, zero to five, selectable
// - Bit 15 turns converter on; resets off
// - Idle-stop bit halts operation in idle
// - 10-bit formats 00 integer, 01 signed integer
// - 10-bit formats 10 fraction, 11 signed fraction
// - 12-bit formats: same four layouts, twelve bits
// - Trigger 000 clears sample; 111 uses counter
// - Pin, timer, PWM1, PWM2 triggers; 100/110 reserved
// - Simultaneous sampling of 2 or 4, else sequential
// - Bits 14, 12, 11, 4 read zero
// - Conversion clock period is divider plus one
// - Auto-sample restarts sampling after each conversion
// - Done set on completion, cleared at next start
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_control #(
  parameter int BUF_DEPTH = 16,
  parameter int NUM_SH = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire sac_pkg::sac_bus_t avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output sac_pkg::sac_bus_t avs_readdata,
  output logic avs_waitrequest,
  input wire logic device_idle,
  input wire logic ext_interrupt_zero,
  input wire logic timer3_compare,
  input wire logic pwm1_interval,
  input wire logic pwm2_interval,
  output logic [NUM_SH-1:0] fe_sample,
  output logic fe_convert_start,
  output logic [1:0] fe_sh_select,
  output logic [2:0] fe_input_select,
  output logic fe_conv_clock,
  input wire logic fe_result_valid,
  input wire logic [11:0] fe_result,
  output logic converter_irq
);
  import sac_pkg::*;
  localparam int PW = $clog2(BUF_DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic ack;
  sac_bus_t rd_value;
  logic [15:0] wv;
  logic sel_c1, sel_c2, sel_c3, sel_ist, sel_imk, sel_buf;
  logic wr_fire, wr1;
  logic converter_on, idle_stop, resolution_select;
  logic [1:0] result_format;
  logic [2:0] trigger_source;
  logic simultaneous_sample, auto_sample, done;
  logic [1:0] channel_count;
  logic [2:0] input_select;
  logic [4:0] sample_time;
  logic [5:0] conv_clock_divider;
  logic [1:0] irq_status, irq_mask, irq_events;
  sac_state_e state;
  logic [1:0] chan, last_ch;
  logic running, sim_eff, sample_bit;
  logic sw_set_sample_active, sw_clr_sample_active, sw_clr_done;
  logic [5:0] tad_cnt;
  logic [4:0] samc_cnt;
  logic [3:0] trig_meta, trig_sync, trig_prev, trig_edge;
  logic hw_trigger, end_sample, conv_step, conv_done, store;
  logic [PW-1:0] wr_ptr;
  logic [15:0] buf_mem [BUF_DEPTH];
  sac_fmt_if fmt_bus ();

  // Merge the enabled byte lanes into the current register value
  function automatic logic [15:0] merge(input logic [15:0] old, input sac_bus_t wd, input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, answer on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_fire = avs_write & ack;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Address decode
  assign sel_c1 = avs_address == `SAC_OFF_CTRL1;
  assign sel_c2 = avs_address == `SAC_OFF_CTRL2;
  assign sel_c3 = avs_address == `SAC_OFF_CTRL3;
  assign sel_ist = avs_address == `SAC_OFF_IRQ_STATUS;
  assign sel_imk = avs_address == `SAC_OFF_IRQ_MASK;
  assign sel_buf = avs_address[`SAC_BUF_SEL_BIT] & (avs_address[1:0] == 2'h0);
  assign sample_bit = state == ST_SAMPLE;
  assign sim_eff = simultaneous_sample & ~resolution_select;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (sel_c1) begin
      rd_value[`SAC_B_ON] = converter_on;
      rd_value[`SAC_B_IDLE_STOP] = idle_stop;
      rd_value[`SAC_B_RES] = resolution_select;
      rd_value[`SAC_F_FMT] = result_format;
      rd_value[`SAC_F_TRIG] = trigger_source;
      rd_value[`SAC_B_SIM] = sim_eff;
      rd_value[`SAC_B_AUTO_SAMPLE] = auto_sample;
      rd_value[`SAC_B_SAMPLE_ACTIVE] = sample_bit;
      rd_value[`SAC_B_DONE] = done;
    end else if (sel_c2) begin
      rd_value[`SAC_F_CHCOUNT] = resolution_select ? 2'h0 : channel_count;
      rd_value[`SAC_F_INSEL] = input_select;
    end else if (sel_c3) begin
      rd_value[`SAC_F_SAMPLE_TIME] = sample_time;
      rd_value[`SAC_F_DIV] = conv_clock_divider;
    end else if (sel_ist) begin
      rd_value[1:0] = irq_status;
    end else if (sel_imk) begin
      rd_value[1:0] = irq_mask;
    end else if (sel_buf) begin
      rd_value[15:0] = buf_mem[avs_address[2+:PW]];
    end
  end

  // Read data captured on the waited edge, stands during the answer cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= rd_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control one
  assign wv = merge(rd_value[15:0], avs_writedata, avs_byteenable);
  assign wr1 = wr_fire & sel_c1;
  assign sw_set_sample_active = wr1 & wv[`SAC_B_SAMPLE_ACTIVE] & ~sample_bit;
  assign sw_clr_sample_active = wr1 & ~wv[`SAC_B_SAMPLE_ACTIVE] & sample_bit;
  assign sw_clr_done = wr1 & ~wv[`SAC_B_DONE];
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      converter_on <= 1'b0;
      idle_stop <= 1'b0;
      resolution_select <= 1'b0;
      result_format <= `SAC_RST_FMT;
      trigger_source <= `SAC_RST_TRIG;
      simultaneous_sample <= 1'b0;
      auto_sample <= 1'b0;
    end else if (wr1) begin
      converter_on <= wv[`SAC_B_ON];
      idle_stop <= wv[`SAC_B_IDLE_STOP];
      // Resolution only follows a write while the converter is off
      if (!converter_on) begin
        resolution_select <= wv[`SAC_B_RES];
      end
      result_format <= wv[`SAC_F_FMT];
      trigger_source <= wv[`SAC_F_TRIG];
      simultaneous_sample <= wv[`SAC_B_SIM] & ~(converter_on ? resolution_select : wv[`SAC_B_RES]);
      auto_sample <= wv[`SAC_B_AUTO_SAMPLE];
    end
  end

  // Control two and three
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_count <= `SAC_RST_CHCOUNT;
      input_select <= `SAC_RST_INSEL;
      sample_time <= `SAC_RST_SAMPLE_TIME;
      conv_clock_divider <= `SAC_RST_DIV;
    end else begin
      if (wr_fire & sel_c2) begin
        channel_count <= wv[`SAC_F_CHCOUNT];
        // Input numbers above five are not kept
        if (wv[`SAC_F_INSEL] <= `SAC_INSEL_MAX) begin
          input_select <= wv[`SAC_F_INSEL];
        end
      end
      if (wr_fire & sel_c3) begin
        sample_time <= wv[`SAC_F_SAMPLE_TIME];
        conv_clock_divider <= wv[`SAC_F_DIV];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status (write one to clear, set wins) and mask
  assign irq_events = {store & (wr_ptr == PW'(BUF_DEPTH - 1)), conv_done};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= `SAC_RST_IRQ;
      irq_mask <= `SAC_RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~((wr_fire & sel_ist) ? wv[1:0] : 2'h0)) | irq_events;
      if (wr_fire & sel_imk) begin
        irq_mask <= wv[1:0];
      end
    end
  end
  assign converter_irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Run state: off stops everything, idle-stop freezes the sequence
  assign running = converter_on & ~(idle_stop & device_idle);
  assign last_ch = (resolution_select | channel_count == 2'h0) ? 2'h0 :
                   (channel_count == 2'h1) ? 2'h1 : 2'h3;

  // Conversion clock: one tick every divider plus one cycles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tad_cnt <= 6'h00;
      fe_conv_clock <= 1'b0;
    end else if (!running) begin
      tad_cnt <= 6'h00;
      fe_conv_clock <= 1'b0;
    end else if (tad_cnt == conv_clock_divider) begin
      tad_cnt <= 6'h00;
      fe_conv_clock <= 1'b1;
    end else begin
      tad_cnt <= tad_cnt + 6'h01;
      fe_conv_clock <= 1'b0;
    end
  end

  // Sample-time counter in conversion clock ticks
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      samc_cnt <= 5'h00;
    end else if (state != ST_SAMPLE) begin
      samc_cnt <= 5'h00;
    end else if (running & fe_conv_clock & (samc_cnt != 5'h1F)) begin
      samc_cnt <= samc_cnt + 5'h01;
    end
  end

  // Trigger pins: two-stage synchroniser then rising-edge pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_meta <= 4'h0;
      trig_sync <= 4'h0;
      trig_prev <= 4'h0;
    end else begin
      trig_meta <= {pwm2_interval, pwm1_interval, timer3_compare, ext_interrupt_zero};
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end
  assign trig_edge = trig_sync & ~trig_prev;

  // Trigger source select
  always_comb begin
    hw_trigger = 1'b0;
    unique case (sac_trig_e'(trigger_source))
      TRIG_MANUAL: hw_trigger = 1'b0;
      TRIG_EXT_PIN: hw_trigger = trig_edge[0];
      TRIG_TIMER: hw_trigger = trig_edge[1];
      TRIG_PWM1: hw_trigger = trig_edge[2];
      TRIG_PWM2: hw_trigger = trig_edge[3];
      TRIG_AUTO: hw_trigger = samc_cnt >= sample_time;
      default: hw_trigger = 1'b0;
    endcase
  end
  assign end_sample = running & (state == ST_SAMPLE) &
                      ((trigger_source == TRIG_MANUAL & sw_clr_sample_active) | hw_trigger);
  assign conv_step = running & (state == ST_CONVERT) & fe_result_valid;
  assign conv_done = conv_step & (chan == last_ch);
  assign store = conv_step;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      chan <= 2'h0;
    end else if (!converter_on) begin
      state <= ST_IDLE;
      chan <= 2'h0;
    end else if (running) begin
      unique case (state)
        ST_IDLE: begin
          if (auto_sample | sw_set_sample_active) begin
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (end_sample) begin
            state <= ST_CONVERT;
            chan <= 2'h0;
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            state <= auto_sample ? ST_SAMPLE : ST_IDLE;
            chan <= 2'h0;
          end else if (conv_step) begin
            chan <= chan + 2'h1;
          end
        end
      endcase
    end
  end

  // Done flag: set wins over the software clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else if (conv_done) begin
      done <= 1'b1;
    end else if (end_sample | sw_clr_done) begin
      done <= 1'b0;
    end
  end

  // Front-end strobes and selects
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fe_convert_start <= 1'b0;
      fe_sh_select <= 2'h0;
      fe_input_select <= `SAC_RST_INSEL;
    end else begin
      fe_convert_start <= end_sample | (conv_step & ~conv_done);
      fe_sh_select <= end_sample ? 2'h0 : (conv_step & ~conv_done) ? chan + 2'h1 : fe_sh_select;
      fe_input_select <= input_select;
    end
  end

  // Tracking per sample-and-hold: sequential mode keeps later ones tracking
  for (genvar k = 0; k < NUM_SH; k++) begin : g_sh
    assign fe_sample[k] = converter_on & (2'(k) <= last_ch) &
                          (sample_bit | (state == ST_CONVERT & ~sim_eff & 2'(k) > chan));
  end

  ////////////////////////////////////////////////////////////////////////
  // Result buffer, refilled from the start when switched off
  assign fmt_bus.raw = fe_result;
  assign fmt_bus.res12 = resolution_select;
  assign fmt_bus.fmt = result_format;
  sac_result_format u_fmt (
    .f(fmt_bus.conv)
  );
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
    end else if (!converter_on) begin
      wr_ptr <= '0;
    end else if (store) begin
      wr_ptr <= (wr_ptr == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= 16'h0000;
      end
    end else if (store) begin
      buf_mem[wr_ptr] <= fmt_bus.word;
    end
  end
endmodule // sac_control
`default_nettype wire

/* sac_control_assertions.sv */
// Port-level checks for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_control_assertions #(
  parameter int NUM_SH = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire sac_pkg::sac_bus_t avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NUM_SH-1:0] fe_sample,
  input wire logic fe_convert_start,
  input wire logic [1:0] fe_sh_select,
  input wire logic [2:0] fe_input_select,
  input wire logic fe_result_valid,
  input wire logic converter_irq
);
  import sac_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // Register bus handshake
  AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("new request without wait state");
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  AST_IDLE_NO_WAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait state without request");
  AST_READ_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  ////////////////////////////////////////////////////////////
  // Front end sequencing
  AST_START_ONE: assert property (fe_convert_start |=> !fe_convert_start)
    else $error("conversion start longer than one cycle");
  AST_START_HOLDS: assert property (fe_convert_start |-> !fe_sample[fe_sh_select])
    else $error("converted channel still tracking");
  AST_SEL_STEADY: assert property ($changed(fe_sh_select) |-> fe_convert_start || fe_sh_select == 2'h0)
    else $error("channel select moved without a start");
  AST_INSEL_RANGE: assert property (fe_input_select <= 3'h5)
    else $error("input select beyond last input");
  ////////////////////////////////////////////////////////////
  // Interrupt level follows its causes
  AST_IRQ_RISE: assert property ($rose(converter_irq) |->
    $past(avs_write) || $past(fe_result_valid) || $past(fe_result_valid, 2))
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(converter_irq) |-> $past(avs_write))
    else $error("interrupt fell without a write");
endmodule // sac_control_assertions
bind sac_control sac_control_assertions #(.NUM_SH(NUM_SH)) u_sac_chk (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .fe_sample(fe_sample),
  .fe_convert_start(fe_convert_start),
  .fe_sh_select(fe_sh_select),
  .fe_input_select(fe_input_select),
  .fe_result_valid(fe_result_valid),
  .converter_irq(converter_irq)
);
`default_nettype wire

/* sac_fe_model.sv */
// Behavioural analog front end answering conversion starts
`timescale 1ns/1ps
`default_nettype none
module sac_fe_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic fe_convert_start,
  input wire logic [1:0] fe_sh_select,
  input wire logic [11:0] base,
  input wire logic slow,
  output logic fe_result_valid,
  output logic [11:0] fe_result
);
  int left;
  // Counts down after a start, then pulses valid with base plus channel
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      left <= 0;
      fe_result_valid <= 1'b0;
      fe_result <= 12'h000;
    end else begin
      fe_result_valid <= 1'b0;
      fe_result <= ~fe_result; // No stale result between answers
      if (fe_convert_start) begin
        left <= slow ? 6 : 1;
      end else if (left == 1) begin
        left <= 0;
        fe_result_valid <= 1'b1;
        fe_result <= base + 12'(fe_sh_select);
      end else if (left > 1) begin
        left <= left - 1;
      end
    end
  end
endmodule // sac_fe_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sac_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  sac_bus_t avs_writedata = 32'h00000000;
  sac_bus_t avs_readdata;
  logic avs_waitrequest;
  logic device_idle = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [3:0] fe_sample;
  logic fe_convert_start;
  logic [1:0] fe_sh_select;
  logic [2:0] fe_input_select;
  logic [3:0] be = 4'h3;
  logic fe_conv_clock;
  logic fe_result_valid;
  logic [11:0] fe_result;
  logic converter_irq;
  logic [11:0] base = 12'h000;
  logic slow = 1'b0;
  logic [31:0] seed = 32'h00015741;
  logic [15:0] q;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int ptr = 0;
  int k;
  ////////////////////////////////////////////////////////////
  // Design and front end
  sac_control dut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .device_idle(device_idle), .ext_interrupt_zero(pins[0]),
    .timer3_compare(pins[1]), .pwm1_interval(pins[2]), .pwm2_interval(pins[3]), .fe_sample(fe_sample),
    .fe_convert_start(fe_convert_start), .fe_sh_select(fe_sh_select), .fe_input_select(fe_input_select),
    .fe_conv_clock(fe_conv_clock), .fe_result_valid(fe_result_valid), .fe_result(fe_result),
    .converter_irq(converter_irq));
  sac_fe_model u_fe (.ref_clk(ref_clk), .reset_n(reset_n), .fe_convert_start(fe_convert_start),
    .fe_sh_select(fe_sh_select), .base(base), .slow(slow), .fe_result_valid(fe_result_valid),
    .fe_result(fe_result));
  ////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] fmtw(input int d, input int w, input int f);
    int v;
    v = d & ((1 << w) - 1);
    case (f)
      1: v = v - (1 << (w - 1));
      2: v = v << (16 - w);
      3: v = (v << (16 - w)) ^ 32'h00008000;
      default: v = v;
    endcase
    return v[15:0];
  endfunction
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr_en, input logic [6:0] a, input logic [15:0] d, output logic [15:0] r);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    avs_writedata <= {16'h0000, d};
    @(posedge ref_clk iff avs_waitrequest === 1'b0);
    r = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] r);
    bus(1'b0, a, 16'h0000, r);
  endtask
  task automatic pulse();
    @(posedge ref_clk);
    pins <= 4'hF;
    repeat (3) @(posedge ref_clk);
    pins <= 4'h0;
  endtask
  // Sample, end sampling, wait for done, check every stored word
  task automatic conv(input logic [15:0] c, input int n);
    logic [15:0] r;
    int i;
    base <= seed[11:0];
    seed = rnd(seed);
    wr(7'h00, c | 16'h0002);
    if (c[7:5] == 3'h0) wr(7'h00, c);
    else pulse();
    i = 0;
    do begin
      rd(7'h00, r);
      i++;
    end while (r[0] !== 1'b1 && i < 40);
    cmp(16'h0001, {15'h0000, r[0]});
    for (i = 0; i < n; i++) begin
      rd(7'h40 + 7'(4 * ptr), r);
      cmp(fmtw(base + i, c[10] ? 12 : 10, c[9:8]), r);
      ptr = (ptr + 1) % 16;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(7'h00, q);
    cmp(16'h0000, q);
    rd(7'h20, q);
    cmp(16'h0000, q);
    wr(7'h00, 16'h5810);
    rd(7'h00, q);
    cmp(16'h0000, q);
    wr(7'h08, 16'h0002);
    // Only the low byte lane may land; sample time keeps its value
    be <= 4'h1;
    wr(7'h08, 16'hFF02);
    be <= 4'h3;
    rd(7'h08, q);
    cmp(16'h0002, q);
    for (int r = 0; r < 2; r++) begin
      wr(7'h00, 16'(r << 10));
      wr(7'h00, 16'(r << 10) | 16'h0008);
      rd(7'h00, q);
      cmp(r ? 16'h0400 : 16'h0008, q);
      wr(7'h00, q | 16'h8000);
      for (int f = 0; f < 4; f++) begin
        slow <= f[0];
        device_idle <= f[1];
        conv(16'h8000 | 16'(r << 10) | 16'(f << 8), 1);
      end
      wr(7'h00, 16'h0000);
      ptr = 0;
    end
    // Idle-stop with the device idle: no conversion clock ticks at all
    wr(7'h00, 16'hA000);
    repeat (6) begin
      @(posedge ref_clk);
      cmp(16'h0000, {15'h0000, fe_conv_clock});
    end
    wr(7'h00, 16'h8000);
    @(posedge ref_clk iff fe_conv_clock === 1'b1);
    k = cyc;
    @(posedge ref_clk iff fe_conv_clock === 1'b1);
    cmp(16'h0003, 16'(cyc - k));
    wr(7'h04, 16'h0100);
    conv(16'h8008, 2);
    rd(7'h0C, q);
    cmp(16'h0001, q);
    wr(7'h10, 16'h0001);
    @(posedge ref_clk);
    cmp(16'h0001, {15'h0000, converter_irq});
    wr(7'h0C, 16'h0001);
    @(posedge ref_clk);
    cmp(16'h0000, {15'h0000, converter_irq});
    // Input select above five is refused; the last legal one stays
    wr(7'h04, 16'h0205);
    wr(7'h04, 16'h0207);
    rd(7'h04, q);
    cmp(16'h0205, q);
    cmp(16'h0005, {13'h0000, fe_input_select});
    conv(16'h8000, 4);
    conv(16'h8008, 4);
    // Auto-sample: hardware restarts sampling right after the sequence
    conv(16'h8004, 4);
    rd(7'h00, q);
    cmp(16'h8007, q);
    for (int t = 1; t < 8; t++) begin
      if (t != 4 && t != 6) conv(16'h8008 | 16'(t << 5), 4);
      else begin
        wr(7'h00, 16'h800A | 16'(t << 5));
        pulse();
        repeat (5) @(posedge ref_clk);
        rd(7'h00, q);
        cmp(16'h800A | 16'(t << 5), q);
        cmp(16'h000F, {12'h000, fe_sample});
      end
    end
    rd(7'h0C, q);
    cmp(16'h0003, q);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
